// file: scr_defs.svh
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define SCR_AW 4
`define SCR_DW 8
`define SCR_PA_W 16

// ----------------------------------------
// register map and reset value
// ----------------------------------------
`define SCR_SYSCTL_OFS 4'h0
`define SCR_RESET_VAL 8'h09
`define SCR_RDATA_IDLE 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCR_BIT_RSV_HI 7
`define SCR_BIT_RSV_LO 6
`define SCR_BIT_MODE_HI 5
`define SCR_BIT_MODE_LO 4
`define SCR_BIT_EXT_RST 3
`define SCR_BIT_EDGE 2
`define SCR_BIT_HOST_EN 1
`define SCR_BIT_RAM_EN 0

// ----------------------------------------
// shared peripheral address windows
// ----------------------------------------
`define SCR_WIN_A_LO 16'hfff0
`define SCR_WIN_A_HI 16'hfff7
`define SCR_WIN_B_LO 16'hfffc
`define SCR_WIN_B_HI 16'hffff

// ----------------------------------------
// edge detector warm-up after reset
// ----------------------------------------
`define SCR_ARM_CNT 2'h3

`endif

// file: scr_pkg.sv
`include "scr_defs.svh"

package scr_pkg;

    // one register access from the cpu side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`SCR_AW-1:0] addr;
        logic [`SCR_DW-1:0] wdata;
    } scr_req_s;

    // control register fields, msb first as laid out in the byte
    typedef struct packed {
        logic [1:0] reserved;
        logic irq_ctrl_mode_hi;
        logic irq_ctrl_mode_lo;
        logic external_reset_flag;
        logic nonmaskable_edge_select;
        logic host_interface_enable;
        logic onchip_ram_enable;
    } scr_ctrl_s;

endpackage

// file: scr_sync.sv
`timescale 1ns/100ps

`include "scr_defs.svh"

// two-stage synchroniser for an asynchronous pin
module scr_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin in, synchronised level out
    input wire logic din,
    output logic dout
);
    logic meta;

    // first stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// file: scr_edge.sv
`timescale 1ns/100ps

`include "scr_defs.svh"

// selectable edge detector, one-cycle request per valid edge
module scr_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // synchronised level and edge choice (1 = rising)
    input wire logic level,
    input wire logic rising_sel,
    // request pulse
    output logic req
);
    logic prev;
    logic [1:0] arm;

    // ----------------------------------------
    // warm-up
    // ----------------------------------------
    // the synchroniser leaves reset at 0; wait until it holds the
    // real pin level so a high pin is not mistaken for a rising edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arm <= 2'h0;
        end else if (arm != `SCR_ARM_CNT) begin
            arm <= arm + 2'h1;
        end
    end

    // ----------------------------------------
    // detection
    // ----------------------------------------
    // comparing against the stored level means a change of the
    // edge choice alone never raises a request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev <= 1'b0;
            req <= 1'b0;
        end else begin
            prev <= level;
            if (arm != `SCR_ARM_CNT) begin
                req <= 1'b0;
            end else if (rising_sel) begin
                req <= level & ~prev;
            end else begin
                req <= ~level & prev;
            end
        end
    end
endmodule

// file: scr_top.sv
// Notes on behaviour
// - bits 7:6 are reserved read/write bits, reset to zero
// - bits 5:4 pick interrupt mode; upper bit read-only zero, lower writable
// - bit 3 reads 1 after a reset from the external reset input
// - bit 3 reads 0 after a reset from watchdog overflow
// - edge select 0, the reset value, requests on falling interrupt edge
// - edge select 1 requests on rising interrupt edge instead
// - host enable 0 maps both shared windows to the two timers
// - host enable 1 maps both shared windows to keypad registers
// - ram enable bit gates on-chip ram; resets to 1
// - ram enable returns to its initial value when reset releases
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps

`include "scr_defs.svh"

module scr_top (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register port
    input wire scr_pkg::scr_req_s REG_REQ,
    output logic [`SCR_DW-1:0] REG_RDATA,
    // reset cause, held by the watchdog across its own reset
    input wire logic WDT_RST_CAUSE,
    // non-maskable interrupt pin and request
    input wire logic NMI_PIN,
    output logic NMI_REQ,
    // shared peripheral window decode
    input wire logic [`SCR_PA_W-1:0] PERIPH_ADDR,
    output logic TIMER_WIN_SEL,
    output logic KEYPAD_WIN_SEL,
    // control outputs
    output logic [1:0] IRQ_MODE,
    output logic RAM_ENABLE
);
    import scr_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    scr_ctrl_s ctrl;
    localparam scr_ctrl_s ctrl_rst = scr_ctrl_s'(`SCR_RESET_VAL);
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic released;
    logic nmi_level;
    logic in_shared;

    // true when an address falls in either shared window
    function automatic logic in_window(input logic [`SCR_PA_W-1:0] a);
        in_window = ((a >= `SCR_WIN_A_LO) && (a <= `SCR_WIN_A_HI))
                 || ((a >= `SCR_WIN_B_LO) && (a <= `SCR_WIN_B_HI));
    endfunction

    // ----------------------------------------
    // access decode
    // ----------------------------------------
    // the register occupies one offset; all others read as zero
    assign hit = (REG_REQ.addr == `SCR_SYSCTL_OFS);
    assign wr_hit = REG_REQ.wr & hit;
    assign rd_hit = REG_REQ.rd & hit;

    // ----------------------------------------
    // reset release marker
    // ----------------------------------------
    // low during reset and in the first cycle after it lets go; the
    // reset cause is sampled there, never under the async reset
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            released <= 1'b0;
        end else begin
            released <= 1'b1;
        end
    end

    // ----------------------------------------
    // reserved bits
    // ----------------------------------------
    // kept as storage so a read-modify-write returns them intact
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl.reserved <= ctrl_rst.reserved;
        end else if (wr_hit) begin
            ctrl.reserved <= REG_REQ.wdata[`SCR_BIT_RSV_HI:`SCR_BIT_RSV_LO];
        end
    end

    // ----------------------------------------
    // interrupt control mode
    // ----------------------------------------
    // upper bit has no write path, so modes 10 and 11 are unreachable
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl.irq_ctrl_mode_hi <= ctrl_rst.irq_ctrl_mode_hi;
        end else begin
            ctrl.irq_ctrl_mode_hi <= ctrl.irq_ctrl_mode_hi;
        end
    end

    // lower mode bit is plain read/write
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl.irq_ctrl_mode_lo <= ctrl_rst.irq_ctrl_mode_lo;
        end else if (wr_hit) begin
            ctrl.irq_ctrl_mode_lo <= REG_REQ.wdata[`SCR_BIT_MODE_LO];
        end
    end

    // ----------------------------------------
    // reset source flag
    // ----------------------------------------
    // reads 1 during reset, then takes the cause on release;
    // cpu writes have no path here
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl.external_reset_flag <= ctrl_rst.external_reset_flag;
        end else if (!released) begin
            ctrl.external_reset_flag <= ~WDT_RST_CAUSE;
        end
    end

    // ----------------------------------------
    // edge select, host enable, ram enable
    // ----------------------------------------
    // edge choice for the non-maskable input
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl.nonmaskable_edge_select <= ctrl_rst.nonmaskable_edge_select;
        end else if (wr_hit) begin
            ctrl.nonmaskable_edge_select <= REG_REQ.wdata[`SCR_BIT_EDGE];
        end
    end

    // steers the shared windows between timers and keypad
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl.host_interface_enable <= ctrl_rst.host_interface_enable;
        end else if (wr_hit) begin
            ctrl.host_interface_enable <= REG_REQ.wdata[`SCR_BIT_HOST_EN];
        end
    end

    // ram gate; the async reset holds it at 1 right up to release
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl.onchip_ram_enable <= ctrl_rst.onchip_ram_enable;
        end else if (wr_hit) begin
            ctrl.onchip_ram_enable <= REG_REQ.wdata[`SCR_BIT_RAM_EN];
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA <= `SCR_RDATA_IDLE;
        end else if (rd_hit) begin
            REG_RDATA <= ctrl;
        end else begin
            REG_RDATA <= `SCR_RDATA_IDLE;
        end
    end

    // ----------------------------------------
    // control outputs
    // ----------------------------------------
    assign IRQ_MODE = {ctrl.irq_ctrl_mode_hi, ctrl.irq_ctrl_mode_lo};
    assign RAM_ENABLE = ctrl.onchip_ram_enable;

    // ----------------------------------------
    // shared window decode
    // ----------------------------------------
    // combinational so the peripheral select lands in the same
    // cycle as the address, like the rest of the bus decode
    assign in_shared = in_window(PERIPH_ADDR);
    assign TIMER_WIN_SEL = in_shared & ~ctrl.host_interface_enable;
    assign KEYPAD_WIN_SEL = in_shared & ctrl.host_interface_enable;

    // ----------------------------------------
    // non-maskable interrupt edge
    // ----------------------------------------
    // pin is asynchronous: two flops before any logic looks at it
    scr_sync u_nmi_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .din(NMI_PIN),
        .dout(nmi_level)
    );

    // request is one cycle after the synchronised level changes
    scr_edge u_nmi_edge (
        .clk(CLK),
        .rst(SYS_RST),
        .level(nmi_level),
        .rising_sel(ctrl.nonmaskable_edge_select),
        .req(NMI_REQ)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // reserved bits keep what was written
    property p_rsv_rw;
        @(posedge CLK) disable iff (SYS_RST)
        wr_hit |=> (ctrl.reserved == $past(REG_REQ.wdata[`SCR_BIT_RSV_HI:`SCR_BIT_RSV_LO]));
    endproperty
    a_rsv_rw: assert property (p_rsv_rw)
        else $error("reserved bits lost a write");

    // upper mode bit never leaves zero, whatever is written
    property p_mode_hi;
        @(posedge CLK) disable iff (SYS_RST)
        wr_hit && REG_REQ.wdata[`SCR_BIT_MODE_HI] |=> (IRQ_MODE[1] == 1'b0);
    endproperty
    a_mode_hi: assert property (p_mode_hi)
        else $error("prohibited interrupt mode reached");

    // lower mode bit follows a write
    property p_mode_lo;
        @(posedge CLK) disable iff (SYS_RST)
        wr_hit |=> (IRQ_MODE[0] == $past(REG_REQ.wdata[`SCR_BIT_MODE_LO]));
    endproperty
    a_mode_lo: assert property (p_mode_lo)
        else $error("lower mode bit did not take write");

    // external reset leaves the flag set after release
    property p_ext_src;
        @(posedge CLK) disable iff (SYS_RST)
        !released && !WDT_RST_CAUSE |=> ctrl.external_reset_flag [*2];
    endproperty
    a_ext_src: assert property (p_ext_src)
        else $error("flag clear after external reset");

    // watchdog reset clears the flag
    property p_wdt_src;
        @(posedge CLK) disable iff (SYS_RST)
        !released && WDT_RST_CAUSE |=> !ctrl.external_reset_flag;
    endproperty
    a_wdt_src: assert property (p_wdt_src)
        else $error("flag set after watchdog reset");

    // falling edge requests when edge select is 0
    property p_nmi_fall;
        @(posedge CLK) disable iff (SYS_RST)
        $fell(nmi_level) && !ctrl.nonmaskable_edge_select
            && released && $past(released, 3) |=> NMI_REQ;
    endproperty
    a_nmi_fall: assert property (p_nmi_fall)
        else $error("falling edge missed");

    // with edge select 1, a request comes only after a rising edge
    property p_nmi_rise;
        @(posedge CLK) disable iff (SYS_RST)
        NMI_REQ && $past(ctrl.nonmaskable_edge_select)
            |-> $past(nmi_level) && !$past(nmi_level, 2);
    endproperty
    a_nmi_rise: assert property (p_nmi_rise)
        else $error("request without rising edge");

    // timer window when host enable is low
    property p_win_timer;
        @(posedge CLK) disable iff (SYS_RST)
        (PERIPH_ADDR == `SCR_WIN_A_LO) && !ctrl.host_interface_enable
            |-> TIMER_WIN_SEL && !KEYPAD_WIN_SEL;
    endproperty
    a_win_timer: assert property (p_win_timer)
        else $error("timer window not decoded");

    // keypad window after host enable is written high
    property p_win_keypad;
        @(posedge CLK) disable iff (SYS_RST)
        wr_hit && REG_REQ.wdata[`SCR_BIT_HOST_EN] ##1 (PERIPH_ADDR == `SCR_WIN_B_HI)
            |-> KEYPAD_WIN_SEL && !TIMER_WIN_SEL;
    endproperty
    a_win_keypad: assert property (p_win_keypad)
        else $error("keypad window not decoded");

    // ram gate follows a write
    property p_ram_wr;
        @(posedge CLK) disable iff (SYS_RST)
        wr_hit |=> (RAM_ENABLE == $past(REG_REQ.wdata[`SCR_BIT_RAM_EN]));
    endproperty
    a_ram_wr: assert property (p_ram_wr)
        else $error("ram enable did not take write");

    // ram is enabled in the first cycle after release
    property p_ram_rel;
        @(posedge CLK) disable iff (SYS_RST)
        !released |-> RAM_ENABLE;
    endproperty
    a_ram_rel: assert property (p_ram_rel)
        else $error("ram disabled at reset release");

    // read-only bits ignore writes
    property p_ro_keep;
        @(posedge CLK) disable iff (SYS_RST)
        wr_hit && released |=> $stable(ctrl.external_reset_flag)
            && $stable(ctrl.irq_ctrl_mode_hi);
    endproperty
    a_ro_keep: assert property (p_ro_keep)
        else $error("read-only bit changed by write");

    // read returns the register one cycle later
    property p_rd_data;
        @(posedge CLK) disable iff (SYS_RST)
        rd_hit |=> (REG_RDATA == $past(ctrl));
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("read data wrong");

    // anything but a register read leaves the read data idle
    property p_rd_idle;
        @(posedge CLK) disable iff (SYS_RST)
        !rd_hit |=> (REG_RDATA == `SCR_RDATA_IDLE);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");

    // the reset source flag moves only in the release cycle
    property p_flag_hold;
        @(posedge CLK) disable iff (SYS_RST)
        released |=> $stable(ctrl.external_reset_flag);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("reset source flag moved after release");

    // a request lasts exactly one cycle, so it is never counted twice
    property p_nmi_pulse;
        @(posedge CLK) disable iff (SYS_RST)
        NMI_REQ |=> !NMI_REQ;
    endproperty
    a_nmi_pulse: assert property (p_nmi_pulse)
        else $error("request longer than one cycle");

    // addresses below both windows select neither peripheral set
    property p_win_below;
        @(posedge CLK) disable iff (SYS_RST)
        (PERIPH_ADDR < `SCR_WIN_A_LO) |-> !TIMER_WIN_SEL && !KEYPAD_WIN_SEL;
    endproperty
    a_win_below: assert property (p_win_below)
        else $error("window selected outside both windows");
endmodule

// file: testbench.sv
`timescale 1ns/100ps

`include "scr_defs.svh"

// one comparison: counts it, reports a mismatch at once
`define CHK(nm, ex, gt) \
    begin \
        n_compared++; \
        if ((ex) !== (gt)) begin \
            n_mismatch++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
        end \
    end

module testbench;
    import scr_pkg::*;

    // ----------------------------------------
    // signals and bench state
    // ----------------------------------------
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    scr_req_s req = '0;
    logic [7:0] rdata;
    logic wdt_cause = 1'b0;
    logic nmi_pin = 1'b1;
    logic nmi_req;
    logic [15:0] paddr = 16'h0000;
    logic timer_sel;
    logic keypad_sel;
    logic [1:0] irq_mode;
    logic ram_en;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h5;
    logic [7:0] shadow;
    logic flag;
    logic [7:0] got;

    scr_top dut (
        .CLK(clk),
        .SYS_RST(sys_rst),
        .REG_REQ(req),
        .REG_RDATA(rdata),
        .WDT_RST_CAUSE(wdt_cause),
        .NMI_PIN(nmi_pin),
        .NMI_REQ(nmi_req),
        .PERIPH_ADDR(paddr),
        .TIMER_WIN_SEL(timer_sel),
        .KEYPAD_WIN_SEL(keypad_sel),
        .IRQ_MODE(irq_mode),
        .RAM_ENABLE(ram_en)
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    // ----------------------------------------
    // expectation functions
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // read-only bits keep their own value whatever was written
    function automatic logic [7:0] exp_reg(logic [7:0] w, logic f);
        return {w[7:6], 1'b0, w[4], f, w[2:0]};
    endfunction

    function automatic logic in_win(logic [15:0] a);
        return (a >= `SCR_WIN_A_LO && a <= `SCR_WIN_A_HI) ||
               (a >= `SCR_WIN_B_LO && a <= `SCR_WIN_B_HI);
    endfunction

    // ----------------------------------------
    // bus and sequence tasks
    // ----------------------------------------
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        if (a == `SCR_SYSCTL_OFS) shadow = d;
    endtask

    // read data stand only in the cycle after the strobe, then idle
    task automatic rd(logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
        @(posedge clk);
        #1 `CHK("rdata_idle", `SCR_RDATA_IDLE, rdata)
    endtask

    task automatic do_reset(logic cause);
        @(posedge clk);
        sys_rst <= 1'b1;
        wdt_cause <= cause;
        repeat (5) @(posedge clk);
        `CHK("ram_en_in_rst", 1'b1, ram_en)
        `CHK("mode_in_rst", 2'h0, irq_mode)
        sys_rst <= 1'b0;
        shadow = 8'h01;
        flag = ~cause;
        repeat (2) @(posedge clk);
        rd(`SCR_SYSCTL_OFS, got);
        `CHK("reg_after_rst", exp_reg(8'h01, flag), got)
        `CHK("ram_en_after_rst", 1'b1, ram_en)
    endtask

    // one pin transition; a request only when it matches the edge select
    task automatic nmi_case(logic sel, logic rise);
        int cnt;
        cnt = 0;
        wr(`SCR_SYSCTL_OFS, {shadow[7:3], sel, shadow[1:0]});
        @(posedge clk);
        nmi_pin <= ~rise;
        repeat (6) @(posedge clk);
        nmi_pin <= rise;
        repeat (8) begin
            @(posedge clk);
            #1 if (nmi_req !== 1'b0) cnt++;
        end
        `CHK("nmi_count", (sel == rise) ? 1 : 0, cnt)
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [3:0] a;
        logic [7:0] w;
        shadow = 8'h01;
        flag = 1'b1;
        do_reset(1'b0);
        // random writes, every other one to a random offset; any unmapped offset must be ignored
        for (int i = 0; i < 24; i++) begin
            w = 8'(rnd());
            a = 4'(rnd());
            if (i % 2 == 0) a = `SCR_SYSCTL_OFS;
            wr(a, w);
            rd(a, got);
            `CHK("reg_read", (a == `SCR_SYSCTL_OFS) ? exp_reg(shadow, flag) : 8'h00, got)
            `CHK("irq_mode", {1'b0, shadow[4]}, irq_mode)
            `CHK("ram_en", shadow[0], ram_en)
        end
        // write then read with no gap, prohibited mode code attempted
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: `SCR_SYSCTL_OFS, wdata: 8'hfe};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: `SCR_SYSCTL_OFS, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        shadow = 8'hfe;
        #1 `CHK("b2b_read", exp_reg(8'hfe, flag), rdata)
        `CHK("ram_off", 1'b0, ram_en)
        // window decode for both host enable settings
        for (int h = 0; h < 2; h++) begin
            // park on the top window so the decode is seen right after the write
            paddr <= `SCR_WIN_B_HI;
            wr(`SCR_SYSCTL_OFS, {shadow[7:2], h[0], shadow[0]});
            for (int i = 0; i < 24; i++) begin
                @(posedge clk);
                paddr <= (i < 16) ? 16'hfff0 + i[15:0] : (i == 16) ? 16'hffef : 16'(rnd());
                #1 `CHK("timer_sel", in_win(paddr) & ~h[0], timer_sel)
                `CHK("keypad_sel", in_win(paddr) & h[0], keypad_sel)
            end
        end
        // every edge select against both pin directions
        for (int i = 0; i < 4; i++) nmi_case(i[1], i[0]);
        // ram off, then watchdog reset, then external reset
        wr(`SCR_SYSCTL_OFS, 8'h00);
        do_reset(1'b1);
        do_reset(1'b0);
        close_out();
    end
endmodule
